// ---- core/cswt_regs.vh ----
// register map, field layout and timing constants of the cyclic sense/wake timer
`ifndef CSWT_REGS_VH
`define CSWT_REGS_VH

// ----------------------------------------
// register word indices
// ----------------------------------------
`define CSWT_ADDR_TIMER_CTRL 4'h0
`define CSWT_ADDR_WAKE_CTRL 4'h1
`define CSWT_ADDR_MODE_CTRL 4'h2
`define CSWT_ADDR_WAKE_STAT 4'h3
`define CSWT_ADDR_STATUS 4'h4

// ----------------------------------------
// timer control fields
// ----------------------------------------
`define CSWT_PERIOD_LSB 0
`define CSWT_ONTIME_LSB 4
`define CSWT_HSFN_LSB 8
`define CSWT_HSFN_CYCLIC 3'h3
`define CSWT_ON_OFF 3'h0
`define CSWT_ON_0P1MS 3'h1
`define CSWT_ON_HIGH 3'h6
`define CSWT_ON_LOW 3'h7

// ----------------------------------------
// wake control / status bits
// ----------------------------------------
`define CSWT_WC_SENSE_EN 0
`define CSWT_WC_TIMER_EN 1
`define CSWT_WC_OTHER_EN 2
`define CSWT_WS_WAKE_FLAG 0
`define CSWT_WS_LEVEL 1
`define CSWT_WS_TIMER_FLAG 2
`define CSWT_WS_CMD_ERR 3

// ----------------------------------------
// modes
// ----------------------------------------
`define CSWT_MODE_NORMAL 3'h0
`define CSWT_MODE_STOP 3'h1
`define CSWT_MODE_SLEEP 3'h2
`define CSWT_MODE_RESTART 3'h3
`define CSWT_MODE_FAILSAFE 3'h4

// ----------------------------------------
// timing
// ----------------------------------------
`define CSWT_CLK_HZ 40000000
`define CSWT_TICK_US 100
`define CSWT_TICK_CYC (`CSWT_CLK_HZ / 1000000 * `CSWT_TICK_US)
`define CSWT_FILTER_NS 16000
`define CSWT_FILTER_CYC ((`CSWT_FILTER_NS * (`CSWT_CLK_HZ / 1000000) + 999) / 1000)

`endif

// ---- core/cswt_timer.v ----
// cyclic sense and cyclic wake timer with avalon-mm register slave
`timescale 1ns/1ps
`include "cswt_regs.vh"

// Functional notes
// - timer starts once a valid on-time is written, whatever else is set, except in restart or fail-safe mode
// - high-side on for on-time each period; level change in on-time wakes
// - sense wake pulls interrupt low in normal/stop, requests supply wake in sleep
// - first sample after start is only the reference
// - 16us filter after on-time; level must differ and stay stable
// - sense wake sets wake flag (in stop only for on-time 001) and fires even if flag already set
// - level status updated from samples only in normal or stop mode
// - in stop mode flag and level update only for on-time code 001
// - command error set when on-time longer than period
// - on-time write with high-side function 011 starts a learning cycle
// - cyclic sense sole source with timer unset: low-power request goes restart
// - fail-safe turns high-side off and switches to static sensing
// - overcurrent or overtemperature disables high-side, ends cyclic sense
// - timer not cleared on fault shutdown, only in restart or fail-safe mode
// - sleep request with pending wake flags wakes at once via restart
// - high-side overcurrent in sleep with sense sole source leaves sleep
// - cyclic wake interrupts in normal/stop, wakes through restart in sleep
// - cyclic wake interrupt at every on-time start except the first
// - sixteen periods from 10 ms to 1000 s
// - fail-safe disables cyclic functions and clears stored wake events
module cswt_timer #(
	parameter TICK_CYC = `CSWT_TICK_CYC,
	parameter FILTER_CYC = `CSWT_FILTER_CYC
) (
	input wire ref_clk_in,
	input wire rst_n_in,
	input wire [3:0] avs_address_in,
	input wire avs_read_in,
	input wire avs_write_in,
	input wire [31:0] avs_writedata_in,
	input wire [3:0] avs_byteenable_in,
	output reg [31:0] avs_readdata_out,
	output wire avs_waitrequest_out,
	input wire sense_wake_input_in,
	input wire hs_overcurrent_in,
	input wire thermal_shutdown_level_two_in,
	output wire high_side_output_out,
	output wire interrupt_out_n_out,
	output wire main_supply_wake_out,
	output wire restart_request_out
);

	// ----------------------------------------
	// period and on-time lookups in 100us ticks
	// ----------------------------------------
	function [23:0] period_ticks;
		input [3:0] sel;
		begin
			case (sel)
			4'h0: period_ticks = 24'd100;
			4'h1: period_ticks = 24'd200;
			4'h2: period_ticks = 24'd500;
			4'h3: period_ticks = 24'd1000;
			4'h4: period_ticks = 24'd2000;
			4'h5: period_ticks = 24'd5000;
			4'h6: period_ticks = 24'd10000;
			4'h7: period_ticks = 24'd20000;
			4'h8: period_ticks = 24'd50000;
			4'h9: period_ticks = 24'd100000;
			4'ha: period_ticks = 24'd200000;
			4'hb: period_ticks = 24'd500000;
			4'hc: period_ticks = 24'd1000000;
			4'hd: period_ticks = 24'd2000000;
			4'he: period_ticks = 24'd5000000;
			default: period_ticks = 24'd10000000;
			endcase
		end
	endfunction

	function [23:0] on_ticks;
		input [2:0] sel;
		begin
			case (sel)
			3'h1: on_ticks = 24'd1;
			3'h2: on_ticks = 24'd3;
			3'h3: on_ticks = 24'd10;
			3'h4: on_ticks = 24'd100;
			3'h5: on_ticks = 24'd200;
			default: on_ticks = 24'd0;
			endcase
		end
	endfunction

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg [3:0] period_q;
	reg [2:0] ontime_q;
	reg [2:0] hsfn_q;
	reg sense_en_q;
	reg timer_en_q;
	reg other_en_q;
	reg [2:0] mode_q;
	reg wake_flag_q;
	reg level_q;
	reg timer_flag_q;
	reg cmd_err_q;
	reg int_q;
	reg hs_fault_q;
	reg running_q;
	reg first_q;
	reg ref_valid_q;
	reg ref_level_q;
	reg learn_q;
	reg [23:0] tick_cnt_q;
	reg [11:0] pre_cnt_q;
	reg [9:0] filt_cnt_q;
	reg filt_act_q;
	reg filt_lvl_q;
	reg filt_bad_q;
	reg wake_req_q;
	reg restart_q;
	reg hs_q;
	reg rd_done_q;
	reg static_lvl_q;

	wire wr = avs_write_in;
	wire wr_timer = wr && avs_address_in == `CSWT_ADDR_TIMER_CTRL && avs_byteenable_in[0];
	wire wr_wstat = wr && avs_address_in == `CSWT_ADDR_WAKE_STAT && avs_byteenable_in[0];
	wire wr_mode = wr && avs_address_in == `CSWT_ADDR_MODE_CTRL && avs_byteenable_in[0];
	wire [2:0] new_on = avs_writedata_in[`CSWT_ONTIME_LSB +: 3];
	wire [3:0] new_per = avs_writedata_in[`CSWT_PERIOD_LSB +: 4];
	wire on_valid_new = new_on != `CSWT_ON_OFF && new_on != `CSWT_ON_HIGH && new_on != `CSWT_ON_LOW;
	wire [2:0] new_mode = avs_writedata_in[2:0];
	wire m_norm = mode_q == `CSWT_MODE_NORMAL;
	wire m_stop = mode_q == `CSWT_MODE_STOP;
	wire m_sleep = mode_q == `CSWT_MODE_SLEEP;
	wire sense_mode = hsfn_q == `CSWT_HSFN_CYCLIC && sense_en_q && !hs_fault_q;
	wire tick = pre_cnt_q == TICK_CYC[11:0] - 12'h1;
	wire at_start = running_q && tick && tick_cnt_q == 24'h0;
	wire in_on = running_q && tick_cnt_q < on_ticks(ontime_q);
	wire on_end = running_q && tick && tick_cnt_q == on_ticks(ontime_q) - 24'h1;
	wire fault = hs_overcurrent_in || thermal_shutdown_level_two_in;
	wire upd_ok = m_norm || (m_stop && ontime_q == `CSWT_ON_0P1MS);
	wire filt_done = filt_act_q && filt_cnt_q == FILTER_CYC[9:0] - 10'h1;
	wire sense_hit = filt_done && !filt_bad_q && sense_wake_input_in == filt_lvl_q
		&& ref_valid_q && filt_lvl_q != ref_level_q;
	wire sense_wake = sense_hit && sense_mode && running_q;
	wire cyc_wake = at_start && timer_en_q && !first_q;
	wire sense_only = sense_en_q && hsfn_q == `CSWT_HSFN_CYCLIC && !timer_en_q && !other_en_q;
	// static sensing in fail-safe: any level change wakes
	wire static_wake = mode_q == `CSWT_MODE_FAILSAFE
		&& sense_wake_input_in != static_lvl_q;

	assign avs_waitrequest_out = avs_read_in && !rd_done_q;
	assign high_side_output_out = hs_q;
	assign interrupt_out_n_out = !int_q;
	assign main_supply_wake_out = wake_req_q;
	assign restart_request_out = restart_q;

	// ----------------------------------------
	// read path: one wait cycle, data from flops
	// ----------------------------------------
	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			avs_readdata_out <= 32'h0;
			rd_done_q <= 1'b0;
		end else begin
			rd_done_q <= avs_read_in && !rd_done_q;
			if (avs_read_in && !rd_done_q) begin
				case (avs_address_in)
				`CSWT_ADDR_TIMER_CTRL: avs_readdata_out <= {21'h0, hsfn_q, 1'b0, ontime_q, period_q};
				`CSWT_ADDR_WAKE_CTRL: avs_readdata_out <= {29'h0, other_en_q, timer_en_q, sense_en_q};
				`CSWT_ADDR_MODE_CTRL: avs_readdata_out <= {29'h0, mode_q};
				`CSWT_ADDR_WAKE_STAT: avs_readdata_out <= {28'h0, cmd_err_q, timer_flag_q,
					level_q, wake_flag_q};
				`CSWT_ADDR_STATUS: avs_readdata_out <= {27'h0, learn_q, ref_level_q, hs_fault_q,
					int_q, running_q};
				default: avs_readdata_out <= 32'h0;
				endcase
			end
		end
	end

	// ----------------------------------------
	// control, timer and sensing
	// ----------------------------------------
	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			period_q <= 4'h0;
			ontime_q <= 3'h0;
			hsfn_q <= 3'h0;
			sense_en_q <= 1'b0;
			timer_en_q <= 1'b0;
			other_en_q <= 1'b0;
			mode_q <= `CSWT_MODE_NORMAL;
			wake_flag_q <= 1'b0;
			level_q <= 1'b0;
			timer_flag_q <= 1'b0;
			cmd_err_q <= 1'b0;
			int_q <= 1'b0;
			hs_fault_q <= 1'b0;
			running_q <= 1'b0;
			first_q <= 1'b0;
			ref_valid_q <= 1'b0;
			ref_level_q <= 1'b0;
			learn_q <= 1'b0;
			tick_cnt_q <= 24'h0;
			pre_cnt_q <= 12'h0;
			filt_cnt_q <= 10'h0;
			filt_act_q <= 1'b0;
			filt_lvl_q <= 1'b0;
			filt_bad_q <= 1'b0;
			wake_req_q <= 1'b0;
			restart_q <= 1'b0;
			hs_q <= 1'b0;
			static_lvl_q <= 1'b0;
		end else begin
			int_q <= 1'b0;
			wake_req_q <= 1'b0;
			restart_q <= 1'b0;
			hs_q <= sense_mode && in_on && mode_q != `CSWT_MODE_FAILSAFE;
			static_lvl_q <= sense_wake_input_in;
			if (wr && avs_address_in == `CSWT_ADDR_WAKE_CTRL && avs_byteenable_in[0]) begin
				sense_en_q <= avs_writedata_in[`CSWT_WC_SENSE_EN];
				timer_en_q <= avs_writedata_in[`CSWT_WC_TIMER_EN];
				other_en_q <= avs_writedata_in[`CSWT_WC_OTHER_EN];
			end
			if (wr_timer) begin
				period_q <= new_per;
				ontime_q <= new_on;
				hsfn_q <= avs_writedata_in[`CSWT_HSFN_LSB +: 3];
				cmd_err_q <= cmd_err_q || on_ticks(new_on) > period_ticks(new_per);
				running_q <= on_valid_new;
				first_q <= 1'b1;
				ref_valid_q <= 1'b0;
				tick_cnt_q <= 24'h0;
				pre_cnt_q <= 12'h0;
				filt_act_q <= 1'b0;
				learn_q <= on_valid_new
					&& avs_writedata_in[`CSWT_HSFN_LSB +: 3] == `CSWT_HSFN_CYCLIC;
				hs_fault_q <= 1'b0;
			end else if (running_q) begin
				pre_cnt_q <= tick ? 12'h0 : pre_cnt_q + 12'h1;
				if (tick) begin
					if (tick_cnt_q == period_ticks(period_q) - 24'h1) begin
						tick_cnt_q <= 24'h0;
					end else begin
						tick_cnt_q <= tick_cnt_q + 24'h1;
					end
				end
				if (at_start) begin
					first_q <= 1'b0;
				end
			end
			// filter window after each on-time
			if (on_end && !wr_timer) begin
				filt_act_q <= 1'b1;
				filt_cnt_q <= 10'h0;
				filt_lvl_q <= sense_wake_input_in;
				filt_bad_q <= 1'b0;
			end else if (filt_act_q && !wr_timer) begin
				filt_cnt_q <= filt_cnt_q + 10'h1;
				if (sense_wake_input_in != filt_lvl_q) begin
					filt_bad_q <= 1'b1;
				end
				if (filt_done) begin
					filt_act_q <= 1'b0;
					if (!filt_bad_q && sense_wake_input_in == filt_lvl_q && sense_mode) begin
						ref_valid_q <= 1'b1;
						ref_level_q <= filt_lvl_q;
						learn_q <= 1'b0;
						if (upd_ok) begin
							level_q <= filt_lvl_q;
						end
					end
				end
			end
			// wake events
			if (sense_wake) begin
				if (m_norm || m_stop) begin
					int_q <= 1'b1;
				end else if (m_sleep) begin
					wake_req_q <= 1'b1;
					mode_q <= `CSWT_MODE_RESTART;
				end
			end
			if (cyc_wake) begin
				if (m_norm || m_stop) begin
					int_q <= 1'b1;
				end else if (m_sleep) begin
					wake_req_q <= 1'b1;
					mode_q <= `CSWT_MODE_RESTART;
				end
			end
			// fault shutdown keeps the timer running
			if (fault && (m_norm || m_stop || m_sleep) && hsfn_q == `CSWT_HSFN_CYCLIC) begin
				hs_fault_q <= 1'b1;
				if (m_sleep && hs_overcurrent_in && sense_only) begin
					mode_q <= `CSWT_MODE_RESTART;
					wake_req_q <= 1'b1;
				end
			end
			// mode requests
			if (wr_mode) begin
				if ((new_mode == `CSWT_MODE_STOP || new_mode == `CSWT_MODE_SLEEP)
					&& sense_only && !running_q) begin
					mode_q <= `CSWT_MODE_RESTART;
				end else if (new_mode == `CSWT_MODE_SLEEP && (wake_flag_q || timer_flag_q)) begin
					mode_q <= `CSWT_MODE_RESTART;
					wake_req_q <= 1'b1;
				end else begin
					mode_q <= new_mode;
				end
			end
			if (mode_q == `CSWT_MODE_RESTART) begin
				running_q <= 1'b0;
				tick_cnt_q <= 24'h0;
				pre_cnt_q <= 12'h0;
				restart_q <= 1'b1;
				if (!wr_mode) begin
					mode_q <= `CSWT_MODE_NORMAL;
				end
			end
			if (mode_q == `CSWT_MODE_FAILSAFE) begin
				running_q <= 1'b0;
				ontime_q <= `CSWT_ON_OFF;
				hsfn_q <= 3'h0;
				if (static_wake && !wr_mode) begin
					mode_q <= `CSWT_MODE_RESTART;
					wake_req_q <= 1'b1;
				end
			end
			// status flags: set wins over clear
			if (mode_q == `CSWT_MODE_FAILSAFE) begin
				wake_flag_q <= 1'b0;
				timer_flag_q <= 1'b0;
			end else begin
				wake_flag_q <= (sense_wake && upd_ok) || (sense_wake && m_sleep)
					|| (wake_flag_q && !(wr_wstat && avs_writedata_in[`CSWT_WS_WAKE_FLAG]));
				timer_flag_q <= cyc_wake
					|| (timer_flag_q && !(wr_wstat && avs_writedata_in[`CSWT_WS_TIMER_FLAG]));
			end
			if (wr_wstat && avs_writedata_in[`CSWT_WS_CMD_ERR]
				&& !(wr_timer && on_ticks(new_on) > period_ticks(new_per))) begin
				cmd_err_q <= 1'b0;
			end
		end
	end

endmodule

// ---- sim/cswt_checker.sv ----
// port checker for the cyclic sense/wake timer
`timescale 1ns/1ps
module cswt_checker (
	input wire ref_clk_in,
	input wire rst_n_in,
	input wire [3:0] avs_address_in,
	input wire avs_read_in,
	input wire avs_write_in,
	input wire [31:0] avs_writedata_in,
	input wire [3:0] avs_byteenable_in,
	input wire [31:0] avs_readdata_out,
	input wire avs_waitrequest_out,
	input wire sense_wake_input_in,
	input wire hs_overcurrent_in,
	input wire thermal_shutdown_level_two_in,
	input wire high_side_output_out,
	input wire interrupt_out_n_out,
	input wire main_supply_wake_out,
	input wire restart_request_out
);
	wire wr0 = avs_write_in && avs_byteenable_in[0] && avs_address_in == 4'h0;
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	property p_oc;
		hs_overcurrent_in [*3] |-> !high_side_output_out;
	endproperty
	a_oc: assert property (p_oc) else $error("high side on in overcurrent");
	property p_ot;
		thermal_shutdown_level_two_in [*3] |-> !high_side_output_out;
	endproperty
	a_ot: assert property (p_ot) else $error("high side on in overtemp");
	property p_int;
		!interrupt_out_n_out |=> interrupt_out_n_out;
	endproperty
	a_int: assert property (p_int) else $error("interrupt pulse too long");
	property p_sup;
		main_supply_wake_out |=> !main_supply_wake_out;
	endproperty
	a_sup: assert property (p_sup) else $error("supply wake pulse too long");
	property p_excl;
		!(main_supply_wake_out && !interrupt_out_n_out);
	endproperty
	a_excl: assert property (p_excl) else $error("interrupt with supply wake");
	property p_fs;
		(avs_write_in && avs_byteenable_in[0] && avs_address_in == 4'h2
			&& avs_writedata_in[2:0] == 3'h4) |=> ##1 !high_side_output_out [*8];
	endproperty
	a_fs: assert property (p_fs) else $error("high side on in fail-safe");
	property p_start;
		(wr0 && avs_writedata_in[6:4] inside {[3'h1:3'h5]}) ##2
			(avs_read_in && avs_address_in == 4'h4) |=> avs_readdata_out[0];
	endproperty
	a_start: assert property (p_start) else $error("timer not started");
	property p_err;
		(wr0 && avs_writedata_in[6:0] == 7'h50) ##2
			(avs_read_in && avs_address_in == 4'h3) |=> avs_readdata_out[3];
	endproperty
	a_err: assert property (p_err) else $error("command error not set");
endmodule
bind cswt_timer cswt_checker cswt_checker_i (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
	.avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
	.avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
	.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
	.sense_wake_input_in(sense_wake_input_in), .hs_overcurrent_in(hs_overcurrent_in),
	.thermal_shutdown_level_two_in(thermal_shutdown_level_two_in),
	.high_side_output_out(high_side_output_out), .interrupt_out_n_out(interrupt_out_n_out),
	.main_supply_wake_out(main_supply_wake_out), .restart_request_out(restart_request_out));

// ---- sim/cswt_switch_model.sv ----
// external switch network on the sense wake input
`timescale 1ns/1ps
module cswt_switch_model (
	input wire switch_closed_in,
	output wire sense_level_out
);
	// switch to battery, pull-down when open
	assign sense_level_out = switch_closed_in;
endmodule

// ---- sim/cswt_timer_tb.sv ----
// self-checking bench for the cyclic sense/wake timer
`timescale 1ns/1ps
module cswt_timer_tb;
	logic clk = 0, rst_n = 0, rd_s = 0, wr_s = 0, sw = 0, oc = 0, ot = 0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wd = 32'h0, rdat, q;
	logic wreq, hs, int_n, sup, rsq, sense;
	int fail_count = 0, total_checks = 0;
	wire [3:0] obs = {hs, rsq, sup, !int_n};
	always #12.5 clk = ~clk;
	cswt_switch_model cswt_switch_model_i (.switch_closed_in(sw), .sense_level_out(sense));
	cswt_timer #(.TICK_CYC(4), .FILTER_CYC(4)) cswt_timer_i (.ref_clk_in(clk),
		.rst_n_in(rst_n), .avs_address_in(adr), .avs_read_in(rd_s), .avs_write_in(wr_s),
		.avs_writedata_in(wd), .avs_byteenable_in(4'hf), .avs_readdata_out(rdat),
		.avs_waitrequest_out(wreq), .sense_wake_input_in(sense), .hs_overcurrent_in(oc),
		.thermal_shutdown_level_two_in(ot), .high_side_output_out(hs),
		.interrupt_out_n_out(int_n), .main_supply_wake_out(sup), .restart_request_out(rsq));
	task complete_run;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, s);
			fail_count++;
		end
	endtask
	task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		wr_s <= w;
		rd_s <= !w;
		adr <= a;
		wd <= d;
		@(posedge clk);
		for (k = 0; wreq !== 1'b0 && k < 20; k++) @(posedge clk);
		q = rdat;
		wr_s <= 0;
		rd_s <= 0;
		fail_count += (wreq !== 1'b0);
		if (wreq !== 1'b0) complete_run;
	endtask
	// counts active cycles of one observed output
	task cnt(input int s, input int lim, input int e, input string nm);
		int c;
		c = 0;
		repeat (lim) begin
			@(posedge clk);
			if (obs[s] === 1'b1) c++;
		end
		chk(nm, c, e);
	endtask
	task t_sense;
		sw <= 1;
		acc(1, 4'h1, 32'h1);
		acc(1, 4'h0, 32'h310);
		acc(0, 4'h4, 0);
		chk("running", q[0], 1);
		chk("learn", q[4], 1);
		cnt(0, 800, 0, "ref int");
		cnt(3, 800, 8, "hs cycles");
		sw <= 0;
		cnt(0, 800, 1, "sense int");
		sw <= 1;
		cnt(0, 800, 1, "repeat int");
		acc(0, 4'h3, 0);
		chk("flag level", q & 32'h3, 32'h3);
		$display("test sense done");
	endtask
	task t_stop;
		acc(1, 4'h3, 32'hf);
		acc(1, 4'h0, 32'h320);
		acc(1, 4'h2, 32'h1);
		cnt(0, 800, 0, "stop ref");
		sw <= 0;
		cnt(0, 800, 1, "stop int");
		acc(0, 4'h3, 0);
		chk("stop flag level", q & 32'h3, 32'h2);
		acc(1, 4'h2, 32'h0);
		$display("test stop done");
	endtask
	task t_err;
		acc(1, 4'h0, 32'h50);
		acc(0, 4'h3, 0);
		chk("err long", q[3], 1);
		acc(1, 4'h3, 32'hf);
		acc(1, 4'h0, 32'h40);
		acc(0, 4'h3, 0);
		chk("err equal", q[3], 0);
		acc(0, 4'h7, 0);
		chk("unmapped", q, 0);
		$display("test err done");
	endtask
	task t_wake;
		acc(1, 4'h1, 32'h2);
		acc(1, 4'h0, 32'h10);
		cnt(0, 1000, 2, "wake int");
		acc(1, 4'h3, 32'hf);
		acc(1, 4'h2, 32'h2);
		cnt(1, 500, 1, "sleep wake");
		acc(0, 4'h4, 0);
		chk("cleared", q[0], 0);
		acc(1, 4'h0, 32'h10);
		cnt(0, 500, 1, "pend int");
		acc(1, 4'h2, 32'h2);
		cnt(2, 20, 1, "pend restart");
		acc(1, 4'h1, 32'h1);
		acc(1, 4'h0, 32'h300);
		acc(1, 4'h2, 32'h1);
		cnt(2, 20, 1, "sole restart");
		acc(1, 4'h0, 32'h310);
		acc(1, 4'h3, 32'hf);
		acc(1, 4'h2, 32'h2);
		oc <= 1;
		cnt(1, 20, 1, "sleep oc");
		oc <= 0;
		$display("test wake done");
	endtask
	task t_fs;
		acc(1, 4'h0, 32'h310);
		oc <= 1;
		repeat (2) @(posedge clk);
		cnt(3, 800, 0, "hs oc");
		oc <= 0;
		acc(0, 4'h4, 0);
		chk("kept", q[0], 1);
		chk("oc fault", q[2], 1);
		acc(1, 4'h0, 32'h310);
		ot <= 1;
		repeat (2) @(posedge clk);
		cnt(3, 800, 0, "hs ot");
		ot <= 0;
		acc(1, 4'h0, 32'h310);
		acc(1, 4'h2, 32'h4);
		repeat (2) @(posedge clk);
		cnt(3, 800, 0, "hs fs");
		acc(0, 4'h3, 0);
		chk("fs flags", q & 32'hd, 0);
		acc(0, 4'h0, 0);
		chk("fs timer", q & 32'h770, 0);
		sw <= !sw;
		cnt(1, 20, 1, "fs wake");
		$display("test fs done");
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1;
		chk("idle int", int_n, 1);
		t_sense;
		t_stop;
		t_err;
		t_wake;
		t_fs;
		complete_run;
	end
endmodule
